// ### src/sleep_timer_map.vh
// Summary of operation
// - 31-bit counter, low slice byte readable
// - High slice byte readable, resets zero
// - Resolution picks bits 15:0/20:5/25:10/30:15
// - Resolution change never disturbs counter
// - Event value bytes reset 0x87/0x6B
// - RC clock interval scales event value
// - Crystal clock interval scales event value
// - Reset bit loads counter with 4
// - Mask bit four gates interrupt
// - Pending flag cleared by writing zero
// - Wake event sets pending flag
// - Enabled event raises CPU sleep flag
// - Event in low modes wakes chip
`ifndef SLEEP_TIMER_MAP_VH
`define SLEEP_TIMER_MAP_VH
// Register addresses in special function space
`define ADDR_IRQ_CTRL 8'hA1
`define ADDR_TMR_CTRL 8'hA2
`define ADDR_EVT_LOW 8'hA3
`define ADDR_EVT_HIGH 8'hA4
`define ADDR_CNT_LOW 8'hA5
`define ADDR_CNT_HIGH 8'hA6
// Field positions
`define BIT_PENDING 0
`define BIT_RSVD1 1
`define BIT_IRQ_EN 4
`define BIT_RSVD5 5
`define BIT_CNT_RESET 2
// Reset values
`define RST_EVT_LOW 8'h6B
`define RST_EVT_HIGH 8'h87
`define RST_CTRL_RSVD 3'h7
`define CNT_RESET_VALUE 31'h00000004
`endif

// ### src/sleep_edge_detect.v
`timescale 1ns/1ps
`default_nettype none
// Turns the asynchronous sleep clock level into a one-cycle tick
module sleep_edge_detect (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Sleep clock level
  input wire level,
  // Rising edge pulse
  output reg tick
);
  reg sync1_q; // First stage, read only by second stage
  reg sync2_q; // Second stage
  reg prev_q; // Delayed copy for edge detection

  // Pipeline and edge detection
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      tick <= 1'b0;
    end else begin
      sync1_q <= level;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      tick <= sync2_q & ~prev_q;
    end
  end
endmodule // sleep_edge_detect
`default_nettype wire

// ### src/sleep_wakeup_timer_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "sleep_timer_map.vh"
// Sleep timer with wake event compare and SFR access
module sleep_wakeup_timer_regs (
  // Clock and reset
  input wire CLK,
  input wire ARST_N,
  // Sleep clock from crystal or RC oscillator, selected outside
  input wire SLEEP_CLK,
  // Special function register port
  input wire [7:0] SFR_ADDR,
  input wire SFR_WR,
  input wire SFR_RD,
  input wire [7:0] SFR_WDATA,
  output reg [7:0] SFR_RDATA,
  output reg SFR_HIT,
  // Power mode state: high while in one of the three lowest sleep modes
  input wire LOW_POWER_MODE,
  // Processor interrupt side
  input wire CPU_SLEEP_IRQ_ENABLE,
  input wire CPU_SLEEP_IRQ_FLAG_CLR,
  output reg CPU_SLEEP_IRQ_FLAG,
  output reg CPU_SLEEP_IRQ_REQ,
  // Wake request to the power manager, one-cycle pulse
  output reg WAKE_TO_ACTIVE
);
  parameter CNT_W = 31; // Counter width

  // Slice selection shared by compare and readback
  function [15:0] slice_sel;
    input [30:0] cnt;
    input [1:0] res;
    begin
      case (res)
        2'h0: slice_sel = cnt[15:0]; // One period per step
        2'h1: slice_sel = cnt[20:5];
        2'h2: slice_sel = cnt[25:10];
        default: slice_sel = cnt[30:15];
      endcase
    end
  endfunction

  wire sleep_tick; // One pulse per rising sleep clock edge
  reg [CNT_W-1:0] count_q; // Free-running sleep counter
  reg [1:0] res_q; // Resolution setting
  reg [2:0] ctrl_rsvd_q; // Reserved control field, stored only
  reg [7:0] evt_low_q; // Event value low byte
  reg [7:0] evt_high_q; // Event value high byte
  reg irq_en_q; // Wake event interrupt enable
  reg rsvd5_q; // Reserved interrupt control bit
  reg rsvd1_q; // Reserved write-zero bit
  reg pending_q; // Wake event pending flag
  reg reset_req_q; // Counter reset waiting for next sleep edge
  reg [15:0] slice_prev_q; // Slice one clock ago, so a match fires once
  wire [15:0] slice; // Currently selected slice
  wire [15:0] evt_value; // Wake event value
  wire match; // Slice equals event value
  reg wake_event; // One-cycle wake event
  wire wr_irq; // Write strobe to interrupt control
  wire wr_ctrl; // Write strobe to timer control

  sleep_edge_detect u_edge (
    .clk(CLK),
    .arst_n(ARST_N),
    .level(SLEEP_CLK),
    .tick(sleep_tick)
  );

  assign slice = slice_sel(count_q, res_q);
  assign evt_value = {evt_high_q, evt_low_q};
  assign match = (slice == evt_value);
  assign wr_irq = SFR_WR && (SFR_ADDR == `ADDR_IRQ_CTRL);
  assign wr_ctrl = SFR_WR && (SFR_ADDR == `ADDR_TMR_CTRL);

  // Counter advances on sleep edges; resolution never touches it
  // Reset is applied on the next sleep edge, as the slow domain would,
  // which is why software waits for edges before relying on it
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count_q <= {CNT_W{1'b0}};
      reset_req_q <= 1'b0;
      slice_prev_q <= 16'h0000;
    end else begin
      // Tracked every clock: a tick-only copy would hold the event high
      // for the whole sleep period
      slice_prev_q <= slice;
      if (wr_ctrl && SFR_WDATA[`BIT_CNT_RESET]) begin
        reset_req_q <= 1'b1;
      end else if (sleep_tick) begin
        reset_req_q <= 1'b0;
      end
      if (sleep_tick) begin
        if (reset_req_q) begin
          count_q <= `CNT_RESET_VALUE;
        end else begin
          count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Event on first clock where slice becomes equal: interval set by value
  // and resolution times the sleep clock period
  always @* begin
    wake_event = match && (slice != slice_prev_q);
  end

  // Register writes
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      res_q <= 2'h0;
      ctrl_rsvd_q <= `RST_CTRL_RSVD;
      evt_low_q <= `RST_EVT_LOW;
      evt_high_q <= `RST_EVT_HIGH;
      irq_en_q <= 1'b0;
      rsvd5_q <= 1'b0;
      rsvd1_q <= 1'b0;
    end else if (SFR_WR) begin
      if (SFR_ADDR == `ADDR_IRQ_CTRL) begin
        irq_en_q <= SFR_WDATA[`BIT_IRQ_EN];
        rsvd5_q <= SFR_WDATA[`BIT_RSVD5]; // Software keeps it zero
        if (!SFR_WDATA[`BIT_RSVD1]) begin
          rsvd1_q <= 1'b0;
        end
      end else if (SFR_ADDR == `ADDR_TMR_CTRL) begin
        res_q <= SFR_WDATA[1:0];
        ctrl_rsvd_q <= SFR_WDATA[6:4];
      end else if (SFR_ADDR == `ADDR_EVT_LOW) begin
        evt_low_q <= SFR_WDATA;
      end else if (SFR_ADDR == `ADDR_EVT_HIGH) begin
        evt_high_q <= SFR_WDATA;
      end
    end
  end

  // Pending flag: event set wins over a write-zero clear
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pending_q <= 1'b0;
    end else if (wake_event) begin
      pending_q <= 1'b1;
    end else if (wr_irq && !SFR_WDATA[`BIT_PENDING]) begin
      pending_q <= 1'b0; // Writing one has no effect
    end
  end

  // Processor-level flag, request and wake
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CPU_SLEEP_IRQ_FLAG <= 1'b0;
      CPU_SLEEP_IRQ_REQ <= 1'b0;
      WAKE_TO_ACTIVE <= 1'b0;
    end else begin
      if (wake_event && irq_en_q) begin
        CPU_SLEEP_IRQ_FLAG <= 1'b1;
      end else if (CPU_SLEEP_IRQ_FLAG_CLR) begin
        CPU_SLEEP_IRQ_FLAG <= 1'b0;
      end
      // Request follows the flag only while the CPU enable is set
      CPU_SLEEP_IRQ_REQ <= (CPU_SLEEP_IRQ_FLAG || (wake_event && irq_en_q)) && CPU_SLEEP_IRQ_ENABLE;
      WAKE_TO_ACTIVE <= wake_event && LOW_POWER_MODE;
    end
  end

  // Read data, registered; unmapped addresses read zero
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SFR_RDATA <= 8'h00;
      SFR_HIT <= 1'b0;
    end else begin
      SFR_HIT <= SFR_RD && (SFR_ADDR >= `ADDR_IRQ_CTRL) && (SFR_ADDR <= `ADDR_CNT_HIGH);
      if (!SFR_RD) begin
        SFR_RDATA <= 8'h00;
      end else if (SFR_ADDR == `ADDR_IRQ_CTRL) begin
        SFR_RDATA <= {2'h0, rsvd5_q, irq_en_q, 2'h0, rsvd1_q, pending_q};
      end else if (SFR_ADDR == `ADDR_TMR_CTRL) begin
        SFR_RDATA <= {1'b0, ctrl_rsvd_q, 2'h0, res_q}; // Reset bit reads zero
      end else if (SFR_ADDR == `ADDR_EVT_LOW) begin
        SFR_RDATA <= evt_low_q;
      end else if (SFR_ADDR == `ADDR_EVT_HIGH) begin
        SFR_RDATA <= evt_high_q;
      end else if (SFR_ADDR == `ADDR_CNT_LOW) begin
        SFR_RDATA <= slice[7:0];
      end else if (SFR_ADDR == `ADDR_CNT_HIGH) begin
        SFR_RDATA <= slice[15:8];
      end else begin
        SFR_RDATA <= 8'h00;
      end
    end
  end
endmodule // sleep_wakeup_timer_regs
`default_nettype wire

// ### tb/sleep_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on reads and interrupt side
module sleep_timer_props (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Register port
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_RDATA,
  input wire logic SFR_HIT,
  // Interrupt and wake side
  input wire logic LOW_POWER_MODE,
  input wire logic CPU_SLEEP_IRQ_ENABLE,
  input wire logic CPU_SLEEP_IRQ_FLAG_CLR,
  input wire logic CPU_SLEEP_IRQ_FLAG,
  input wire logic CPU_SLEEP_IRQ_REQ,
  input wire logic WAKE_TO_ACTIVE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Control and interrupt register reads
  sequence s_rd_ctl; SFR_RD && SFR_ADDR == 8'hA2; endsequence
  sequence s_rd_irq; SFR_RD && SFR_ADDR == 8'hA1; endsequence
  a_map_hit: assert property (
    SFR_RD && SFR_ADDR >= 8'hA1 && SFR_ADDR <= 8'hA6 |=> SFR_HIT) else $error("no hit");
  a_unmap_zero: assert property (
    SFR_RD && SFR_ADDR > 8'hA6 |=> !SFR_HIT && SFR_RDATA == 8'h00) else $error("unmapped read");
  a_reset_bit_zero: assert property (
    s_rd_ctl |=> SFR_RDATA[2] == 1'b0 && SFR_RDATA[7] == 1'b0) else $error("ctrl read");
  a_irq_unused_zero: assert property (
    s_rd_irq |=> SFR_RDATA[7:6] == 2'h0 && SFR_RDATA[3:2] == 2'h0) else $error("irq read");
  a_req_needs_en: assert property (
    CPU_SLEEP_IRQ_REQ |-> $past(CPU_SLEEP_IRQ_ENABLE)) else $error("req unmasked");
  a_flag_holds: assert property (
    CPU_SLEEP_IRQ_FLAG && !CPU_SLEEP_IRQ_FLAG_CLR |=> CPU_SLEEP_IRQ_FLAG) else $error("flag lost");
  a_wake_pulse: assert property (
    WAKE_TO_ACTIVE |-> $past(LOW_POWER_MODE) ##1 !WAKE_TO_ACTIVE) else $error("wake pulse");
  a_flag_with_wake: assert property (
    $rose(CPU_SLEEP_IRQ_FLAG) && $past(LOW_POWER_MODE) |-> WAKE_TO_ACTIVE) else $error("no wake");
endmodule // sleep_timer_props
bind sleep_wakeup_timer_regs sleep_timer_props u_props (.CLK(CLK), .ARST_N(ARST_N), .SFR_RD(SFR_RD),
  .SFR_ADDR(SFR_ADDR), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .LOW_POWER_MODE(LOW_POWER_MODE),
  .CPU_SLEEP_IRQ_ENABLE(CPU_SLEEP_IRQ_ENABLE), .CPU_SLEEP_IRQ_FLAG_CLR(CPU_SLEEP_IRQ_FLAG_CLR),
  .CPU_SLEEP_IRQ_FLAG(CPU_SLEEP_IRQ_FLAG), .CPU_SLEEP_IRQ_REQ(CPU_SLEEP_IRQ_REQ),
  .WAKE_TO_ACTIVE(WAKE_TO_ACTIVE));
`default_nettype wire

// ### tb/sleep_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Sleep oscillator, runs only in bursts so tick counts stay exact
module sleep_osc_model #(parameter int HALF_NS = 250) (
  // Sleep clock level
  output var logic sleep_clk
);
  // Idle low between bursts
  initial sleep_clk = 1'b0;
  // Half period of five core cycles keeps it slow enough to sample
  task automatic pulses(input int n);
    repeat (n) begin
      #HALF_NS sleep_clk = 1'b1;
      #HALF_NS sleep_clk = 1'b0;
    end
  endtask
endmodule // sleep_osc_model
`default_nettype wire

// ### tb/sleep_wakeup_timer_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Register-level bench for the sleep timer
module sleep_wakeup_timer_regs_tb_top;
  logic clk = 0, arst_n = 0, wr_en = 0, rd_en = 0, lpm = 0, cpu_en = 0, clr = 0, wake_seen = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  wire sleep_clk, hit, flag, req, wake;
  wire [7:0] rdata;
  int err_count = 0;
  int samples_checked = 0;
  sleep_osc_model u_osc (.sleep_clk(sleep_clk));
  sleep_wakeup_timer_regs u_dut (.CLK(clk), .ARST_N(arst_n), .SLEEP_CLK(sleep_clk), .SFR_ADDR(addr),
    .SFR_WR(wr_en), .SFR_RD(rd_en), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SFR_HIT(hit),
    .LOW_POWER_MODE(lpm), .CPU_SLEEP_IRQ_ENABLE(cpu_en), .CPU_SLEEP_IRQ_FLAG_CLR(clr),
    .CPU_SLEEP_IRQ_FLAG(flag), .CPU_SLEEP_IRQ_REQ(req), .WAKE_TO_ACTIVE(wake));
  // Core clock, 50 ns
  initial forever #25 clk = ~clk;
  // Wake stands one cycle only, so keep a sticky copy
  always @(posedge clk) if (wake === 1'b1) wake_seen <= 1'b1;
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // One write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk) #1 wr_en = 1'b0;
  endtask
  // Read data lands the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1 addr = a;
    rd_en = 1'b1;
    @(posedge clk) #1 rd_en = 1'b0;
    chk($sformatf("reg %h", a), rdata, exp);
  endtask
  // Sleep edges plus room for the synchroniser
  task automatic ticks(input int n);
    u_osc.pulses(n);
    repeat (6) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200us;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    rd(8'hA1, 8'h00);
    rd(8'hA2, 8'h70);
    rd(8'hA3, 8'h6B);
    rd(8'hA4, 8'h87);
    rd(8'hA6, 8'h00);
    rd(8'hB0, 8'h00);
    wr(8'hA3, 8'h0A);
    wr(8'hA4, 8'h00);
    wr(8'hA5, 8'hFF);
    rd(8'hA3, 8'h0A);
    rd(8'hA5, 8'h00);
    $display("test registers done");
    // Counter reset lands on the next sleep edge
    wr(8'hA2, 8'h04);
    ticks(1);
    rd(8'hA5, 8'h04);
    rd(8'hA2, 8'h00);
    ticks(2);
    wr(8'hA2, 8'h01);
    rd(8'hA5, 8'h00);
    wr(8'hA2, 8'h00);
    rd(8'hA5, 8'h06);
    $display("test counter done");
    lpm = 1'b1;
    cpu_en = 1'b1;
    wr(8'hA1, 8'h10);
    ticks(4);
    rd(8'hA1, 8'h11);
    chk("flag", {7'h00, flag}, 8'h01);
    chk("req", {7'h00, req}, 8'h01);
    chk("wake", {7'h00, wake_seen}, 8'h01);
    wr(8'hA1, 8'h11);
    rd(8'hA1, 8'h11);
    wr(8'hA1, 8'h10);
    rd(8'hA1, 8'h10);
    $display("test event done");
    // Masked event: count reloads to 4, then six steps to the value
    @(posedge clk) #1 clr = 1'b1;
    @(posedge clk) #1 clr = 1'b0;
    wr(8'hA1, 8'h00);
    wr(8'hA2, 8'h04);
    ticks(7);
    rd(8'hA1, 8'h01);
    chk("flag", {7'h00, flag}, 8'h00);
    $display("test mask done");
    report_and_stop();
  end
endmodule // sleep_wakeup_timer_regs_tb_top
`default_nettype wire
